// >>> design/tlms_pkg.sv
/*
  Package of the torque limit and control mode selector: register map, field layouts,
  reset values, limit ranges and control-mode encodings.
  Assumes a 32-bit APB register bus and a 100 MHz system clock.
*/
`default_nettype none
package tlms_pkg;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] TLMS_OFS_FWD_INT  = 8'h00;
  localparam logic [7:0] TLMS_OFS_REV_INT  = 8'h04;
  localparam logic [7:0] TLMS_OFS_FWD_EXT  = 8'h08;
  localparam logic [7:0] TLMS_OFS_REV_EXT  = 8'h0C;
  localparam logic [7:0] TLMS_OFS_MODE     = 8'h10;
  localparam logic [7:0] TLMS_OFS_FUNC     = 8'h14;
  localparam logic [7:0] TLMS_OFS_MOTORMAX = 8'h18;
  localparam logic [7:0] TLMS_OFS_STATUS   = 8'h1C;
  localparam logic [7:0] TLMS_OFS_APPLIED  = 8'h20;

  // ------------------------------------------------------------------
  // Limits in percent of rated torque
  // ------------------------------------------------------------------
  localparam int         TLMS_LIM_W        = 9;
  localparam logic [8:0] TLMS_LIM_MAX      = 9'h12C;
  localparam logic [8:0] TLMS_INT_RESET    = 9'h12C;
  localparam logic [8:0] TLMS_EXT_RESET    = 9'h064;
  localparam logic [8:0] TLMS_MOTOR_RESET  = 9'h12C;
  localparam int         TLMS_ADC_W        = 12;

  // ------------------------------------------------------------------
  // Field layouts
  // ------------------------------------------------------------------
  localparam int         TLMS_MODE_LSB     = 4;
  localparam int         TLMS_MODE_MSB     = 7;
  localparam int         TLMS_FUNC_LSB     = 8;
  localparam int         TLMS_FUNC_MSB     = 11;
  localparam logic [3:0] TLMS_FUNC_TREFLIM = 4'h1;
  localparam logic [15:0] TLMS_MODE_RESET  = 16'h0000;
  localparam logic [15:0] TLMS_FUNC_RESET  = 16'h0000;
  localparam int         TLMS_STAT_ANAEN   = 4;
  localparam int         TLMS_STAT_FWDEXT  = 5;
  localparam int         TLMS_STAT_REVEXT  = 6;
  localparam int         TLMS_STAT_ALT     = 7;
  localparam int         TLMS_APPL_REV_LSB = 16;

  // ------------------------------------------------------------------
  // Control mode field values
  // ------------------------------------------------------------------
  localparam logic [3:0] TLMS_MF_SPD_SPD   = 4'h4;
  localparam logic [3:0] TLMS_MF_SPD_POS   = 4'h5;
  localparam logic [3:0] TLMS_MF_SPD_TRQ   = 4'h6;
  localparam logic [3:0] TLMS_MF_POS_SPD   = 4'h7;
  localparam logic [3:0] TLMS_MF_POS_TRQ   = 4'h8;
  localparam logic [3:0] TLMS_MF_TRQ_SPD   = 4'h9;
  localparam logic [3:0] TLMS_MF_SPD_ZCL   = 4'hA;
  localparam logic [3:0] TLMS_MF_POS_INH   = 4'hB;
  localparam logic [3:0] TLMS_MF_POS_CON   = 4'hC;
  localparam logic [3:0] TLMS_MF_SPD_PAR   = 4'hD;
  localparam logic [3:0] TLMS_MF_SPECIAL   = 4'hE;

  // Active control mode
  typedef enum logic [3:0] {
    TLMS_CM_NONE    = 4'h0,
    TLMS_CM_SPD_CON = 4'h1,
    TLMS_CM_SPD_ANA = 4'h2,
    TLMS_CM_POS_PUL = 4'h3,
    TLMS_CM_TRQ_ANA = 4'h4,
    TLMS_CM_ZCLAMP  = 4'h5,
    TLMS_CM_POS_INH = 4'h6,
    TLMS_CM_POS_CON = 4'h7,
    TLMS_CM_SPD_PAR = 4'h8,
    TLMS_CM_SPECIAL = 4'h9
  } tlms_mode_t;

  // Pairing chosen by the mode field: primary and alternate
  typedef struct packed {
    tlms_mode_t primary;
    tlms_mode_t alternate;
  } tlms_pair_t;
endpackage
`default_nettype wire

// >>> design/tlms_sync.sv
/*
  Two-flop synchroniser for the sequence input pins.
  Assumes asynchronous pin levels and one clock, mclk.
*/
`default_nettype none
module tlms_sync #(
  parameter int       W        = 2,
  parameter logic [1:0] RST_VAL = 2'h3
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1_reg <= W'(RST_VAL);
      stage2_reg <= W'(RST_VAL);
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// >>> design/tlms_mode_map.sv
/*
  Decoder of the control mode field into primary and alternate control modes.
  Assumes a registered field value from the same clock domain.
*/
`default_nettype none
module tlms_mode_map
  import tlms_pkg::*;
(
  input  wire logic [3:0] modeField,
  output tlms_pair_t      pairOut
);
  always_comb begin
    pairOut = '{primary: TLMS_CM_NONE, alternate: TLMS_CM_NONE};
    case (modeField)
      TLMS_MF_SPD_SPD: pairOut = '{TLMS_CM_SPD_CON, TLMS_CM_SPD_ANA};
      TLMS_MF_SPD_POS: pairOut = '{TLMS_CM_SPD_CON, TLMS_CM_POS_PUL};
      TLMS_MF_SPD_TRQ: pairOut = '{TLMS_CM_SPD_CON, TLMS_CM_TRQ_ANA};
      TLMS_MF_POS_SPD: pairOut = '{TLMS_CM_POS_PUL, TLMS_CM_SPD_ANA};
      TLMS_MF_POS_TRQ: pairOut = '{TLMS_CM_POS_PUL, TLMS_CM_TRQ_ANA};
      TLMS_MF_TRQ_SPD: pairOut = '{TLMS_CM_TRQ_ANA, TLMS_CM_SPD_ANA};
      TLMS_MF_SPD_ZCL: pairOut = '{TLMS_CM_SPD_ANA, TLMS_CM_ZCLAMP};
      TLMS_MF_POS_INH: pairOut = '{TLMS_CM_POS_PUL, TLMS_CM_POS_INH};
      TLMS_MF_POS_CON: pairOut = '{TLMS_CM_POS_CON, TLMS_CM_POS_CON};
      TLMS_MF_SPD_PAR: pairOut = '{TLMS_CM_SPD_PAR, TLMS_CM_SPD_PAR};
      TLMS_MF_SPECIAL: pairOut = '{TLMS_CM_SPECIAL, TLMS_CM_SPECIAL};
      default:         pairOut = '{TLMS_CM_NONE, TLMS_CM_NONE};
    endcase
  end
endmodule
`default_nettype wire

// >>> design/tlms_torque_limit_mode_select.sv
/*
  Top of the torque limit and control mode selector: APB register file, selection of
  forward and reverse torque limits, analog limit path and control mode selection.
  Assumes APB master on mclk, sequence inputs from pins, an analog limit sample
  (magnitude code and sign) already on mclk, and a sample strobe from the control loop.
*/
// Added by the designer: register access over APB and the address map.
// Operation
// - Forward select low picks external forward limit
// - Reverse select low picks external reverse limit
// - External limits range 0 to 300 percent
// - Analog limit only in speed/position modes
// - Analog limit uses magnitude, both directions
// - Analog limit used only when config digit 1
// - Fields 4,5,6 pair contact speed modes
// - Fields 7,8 pair pulse position modes
// - Field 9 pairs torque with speed
// - Field B inhibit, field A zero clamp
// - Fields C,D,E single special modes
// - Both selects high switch paired mode, fields 4,5,6 only
// - Internal limits always bound, 0 to 300
// - Clamp any limit to motor maximum
`default_nettype none
module tlms_torque_limit_mode_select
  import tlms_pkg::*;
#(
  parameter int ADC_W = TLMS_ADC_W
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             fwdLimitSelectN,
  input  wire logic             revLimitSelectN,
  input  wire logic [ADC_W-1:0] anaLimitMag,
  input  wire logic             anaLimitNeg,
  input  wire logic             controlUpdate,
  output logic      [8:0]       fwdTorqueLimit,
  output logic      [8:0]       revTorqueLimit,
  output logic      [3:0]       activeMode,
  output logic                  modeSwitched
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [8:0] limitClip(input logic [8:0] v);
    limitClip = (v > TLMS_LIM_MAX) ? TLMS_LIM_MAX : v;
  endfunction

  function automatic logic [8:0] minLim(input logic [8:0] a, input logic [8:0] b);
    minLim = (a < b) ? a : b;
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [8:0]  fwdIntLim_reg;
  logic [8:0]  revIntLim_reg;
  logic [8:0]  fwdExtLim_reg;
  logic [8:0]  revExtLim_reg;
  logic [15:0] controlModeField_reg;
  logic [15:0] functionConfigField_reg;
  logic [8:0]  motorMax_reg;
  logic [1:0]  selSync;
  logic        fwdSelN;
  logic        revSelN;
  tlms_pair_t  modePair;
  logic        apbWrite;
  logic        apbRead;
  logic        addrOk;

  tlms_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_sync (
    .mclk    (mclk),
    .reset   (reset),
    .pinIn   ({fwdLimitSelectN, revLimitSelectN}),
    .syncOut (selSync)
  );
  assign fwdSelN = selSync[1];
  assign revSelN = selSync[0];

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  always_comb begin
    case (paddr)
      TLMS_OFS_FWD_INT, TLMS_OFS_REV_INT, TLMS_OFS_FWD_EXT, TLMS_OFS_REV_EXT,
      TLMS_OFS_MODE, TLMS_OFS_FUNC, TLMS_OFS_MOTORMAX, TLMS_OFS_STATUS,
      TLMS_OFS_APPLIED: addrOk = 1'b1;
      default:          addrOk = 1'b0;
    endcase
  end

  // Zero wait states: access phase always completes
  assign apbWrite = psel && penable && pwrite && addrOk;
  // Unmapped writes also load the read data (zero), so an error never carries data
  assign apbRead  = psel && !penable && !(pwrite && addrOk);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
    end
  end

  // Range-checked writes; limit values in bits 8:0 above 300 percent saturate at 300
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fwdIntLim_reg           <= TLMS_INT_RESET;
      revIntLim_reg           <= TLMS_INT_RESET;
      fwdExtLim_reg           <= TLMS_EXT_RESET;
      revExtLim_reg           <= TLMS_EXT_RESET;
      controlModeField_reg    <= TLMS_MODE_RESET;
      functionConfigField_reg <= TLMS_FUNC_RESET;
      motorMax_reg            <= TLMS_MOTOR_RESET;
    end else if (apbWrite) begin
      case (paddr)
        TLMS_OFS_FWD_INT:  fwdIntLim_reg <= limitClip(pwdata[8:0]);
        TLMS_OFS_REV_INT:  revIntLim_reg <= limitClip(pwdata[8:0]);
        TLMS_OFS_FWD_EXT:  fwdExtLim_reg <= limitClip(pwdata[8:0]);
        TLMS_OFS_REV_EXT:  revExtLim_reg <= limitClip(pwdata[8:0]);
        TLMS_OFS_MODE:     controlModeField_reg    <= pwdata[15:0];
        TLMS_OFS_FUNC:     functionConfigField_reg <= pwdata[15:0];
        TLMS_OFS_MOTORMAX: motorMax_reg  <= limitClip(pwdata[8:0]);
        default:           motorMax_reg  <= motorMax_reg;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------------
  tlms_mode_map u_map (
    .modeField (controlModeField_reg[TLMS_MODE_MSB:TLMS_MODE_LSB]),
    .pairOut   (modePair)
  );

  logic       altSel;
  logic       pairSwitch;
  tlms_mode_t modeNow;
  logic [3:0] mf;
  assign mf = controlModeField_reg[TLMS_MODE_MSB:TLMS_MODE_LSB];
  assign pairSwitch = (mf == TLMS_MF_SPD_SPD) || (mf == TLMS_MF_SPD_POS)
                   || (mf == TLMS_MF_SPD_TRQ);
  // Both selects high (off) take the paired mode in fields 4 to 6
  assign altSel  = pairSwitch && fwdSelN && revSelN;
  assign modeNow = altSel ? modePair.alternate : modePair.primary;

  // ------------------------------------------------------------------
  // Limit selection
  // ------------------------------------------------------------------
  logic       anaEnable;
  logic       anaModeOk;
  logic [8:0] anaLim;
  logic [8:0] fwdSel;
  logic [8:0] revSel;
  logic [8:0] fwdNext;
  logic [8:0] revNext;
  logic [ADC_W+8:0] anaScaled;

  // Sign is ignored: magnitude maps full scale to 300 percent
  assign anaScaled = (ADC_W+9)'(anaLimitMag) * (ADC_W+9)'(TLMS_LIM_MAX);
  assign anaLim    = anaScaled[ADC_W+8:ADC_W];
  assign anaModeOk = (modeNow == TLMS_CM_SPD_CON) || (modeNow == TLMS_CM_SPD_ANA)
                  || (modeNow == TLMS_CM_POS_PUL) || (modeNow == TLMS_CM_POS_CON)
                  || (modeNow == TLMS_CM_SPD_PAR) || (modeNow == TLMS_CM_ZCLAMP)
                  || (modeNow == TLMS_CM_POS_INH);
  assign anaEnable = anaModeOk &&
    (functionConfigField_reg[TLMS_FUNC_MSB:TLMS_FUNC_LSB] == TLMS_FUNC_TREFLIM);

  // Select pins are assumed dedicated to this function by the host
  assign fwdSel  = fwdSelN ? fwdIntLim_reg : minLim(fwdExtLim_reg, fwdIntLim_reg);
  assign revSel  = revSelN ? revIntLim_reg : minLim(revExtLim_reg, revIntLim_reg);
  // Internal limit always bounds; motor maximum clamps everything
  assign fwdNext = minLim(minLim(anaEnable ? minLim(fwdSel, anaLim) : fwdSel,
                                 fwdIntLim_reg), motorMax_reg);
  assign revNext = minLim(minLim(anaEnable ? minLim(revSel, anaLim) : revSel,
                                 revIntLim_reg), motorMax_reg);

  logic anaSignIgnored;
  assign anaSignIgnored = anaLimitNeg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fwdTorqueLimit <= '0;
      revTorqueLimit <= '0;
      activeMode     <= TLMS_CM_NONE;
      modeSwitched   <= 1'b0;
    end else if (controlUpdate) begin
      fwdTorqueLimit <= fwdNext;
      revTorqueLimit <= revNext;
      activeMode     <= modeNow;
      modeSwitched   <= altSel;
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata <= '0;
    end else if (apbRead) begin
      case (paddr)
        TLMS_OFS_FWD_INT:  prdata <= {23'h0, fwdIntLim_reg};
        TLMS_OFS_REV_INT:  prdata <= {23'h0, revIntLim_reg};
        TLMS_OFS_FWD_EXT:  prdata <= {23'h0, fwdExtLim_reg};
        TLMS_OFS_REV_EXT:  prdata <= {23'h0, revExtLim_reg};
        TLMS_OFS_MODE:     prdata <= {16'h0, controlModeField_reg};
        TLMS_OFS_FUNC:     prdata <= {16'h0, functionConfigField_reg};
        TLMS_OFS_MOTORMAX: prdata <= {23'h0, motorMax_reg};
        TLMS_OFS_STATUS: begin
          prdata                   <= {28'h0, modeNow};
          prdata[TLMS_STAT_ANAEN]  <= anaEnable;
          prdata[TLMS_STAT_FWDEXT] <= ~fwdSelN;
          prdata[TLMS_STAT_REVEXT] <= ~revSelN;
          prdata[TLMS_STAT_ALT]    <= altSel;
        end
        TLMS_OFS_APPLIED:  prdata <= {7'h0, revTorqueLimit, 7'h0, fwdTorqueLimit};
        default:           prdata <= {31'h0, anaSignIgnored & 1'b0};
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> bench/tlms_monitor.sv
/* Checker of the selector ports: APB answer, limit hold, range and mode switching.
   Assumes a bind to the selector top, one clock mclk, reset async active high. */
`default_nettype none
module tlms_monitor (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fwdLimitSelectN,
  input wire logic        revLimitSelectN,
  input wire logic        controlUpdate,
  input wire logic [8:0]  fwdTorqueLimit,
  input wire logic [8:0]  revTorqueLimit,
  input wire logic [3:0]  activeMode,
  input wire logic        modeSwitched
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    s_setup ##0 (paddr > 8'h20);
  endsequence
  sequence s_good;
    s_setup ##0 (paddr <= 8'h20 && paddr[1:0] == 2'h0);
  endsequence
  property p_rdy;
    s_setup |=> pready && psel && penable;
  endproperty
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  property p_err;
    s_bad |=> pslverr;
  endproperty
  property p_ok;
    s_good |=> !pslverr;
  endproperty
  property p_err_data;
    pslverr |-> prdata == 32'h0;
  endproperty
  property p_lim_hold;
    !controlUpdate |=> $stable(fwdTorqueLimit) && $stable(revTorqueLimit);
  endproperty
  property p_mode_hold;
    !controlUpdate |=> $stable(activeMode) && $stable(modeSwitched);
  endproperty
  property p_range;
    fwdTorqueLimit <= 9'h12C && revTorqueLimit <= 9'h12C;
  endproperty
  property p_switch;
    $rose(modeSwitched) |-> $past(fwdLimitSelectN, 3) && $past(revLimitSelectN, 3);
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("no error for unmapped address");
  a_ok: assert property (p_ok) else $error("error for mapped address");
  a_err_data: assert property (p_err_data) else $error("data with error");
  a_lim_hold: assert property (p_lim_hold) else $error("limit moved without update");
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without update");
  a_range: assert property (p_range) else $error("limit above 300");
  a_switch: assert property (p_switch) else $error("switch without both selects off");
endmodule
`default_nettype wire

// >>> bench/tlms_host_model.sv
/* Host controller model that drives the two limit select pins.
   Assumes request levels from the bench, one clock mclk. */
`default_nettype none
module tlms_host_model (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic fwdReq,
  input  wire logic revReq,
  output logic      fwdLimitSelectN,
  output logic      revLimitSelectN
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Select pins, only the limit select levels
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fwdLimitSelectN <= 1'h1;
      revLimitSelectN <= 1'h1;
    end else begin
      fwdLimitSelectN <= fwdReq;
      revLimitSelectN <= revReq;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
/* Testbench of the selector: APB master tasks, select pins via host model.
   Assumes zero wait APB and outputs loaded one cycle after controlUpdate. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tlms_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic        controlUpdate = 0, anaLimitNeg = 0, fwdReq = 1, revReq = 1;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [11:0] anaLimitMag = 12'h0;
  logic        pready, pslverr, fwdLimitSelectN, revLimitSelectN, modeSwitched;
  logic [8:0]  fwdTorqueLimit, revTorqueLimit;
  logic [3:0]  activeMode;
  logic [3:0]  pri [11] = '{4'h1, 4'h1, 4'h1, 4'h3, 4'h3, 4'h4, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9};
  int          badCount = 0, totalChecks = 0, cyc = 0;
  always #5 mclk = ~mclk;
  tlms_torque_limit_mode_select i_tlms_torque_limit_mode_select (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fwdLimitSelectN(fwdLimitSelectN),
    .revLimitSelectN(revLimitSelectN), .anaLimitMag(anaLimitMag), .anaLimitNeg(anaLimitNeg),
    .controlUpdate(controlUpdate), .fwdTorqueLimit(fwdTorqueLimit),
    .revTorqueLimit(revTorqueLimit), .activeMode(activeMode), .modeSwitched(modeSwitched));
  tlms_host_model i_tlms_host_model (.mclk(mclk), .reset(reset), .fwdReq(fwdReq),
    .revReq(revReq), .fwdLimitSelectN(fwdLimitSelectN), .revLimitSelectN(revLimitSelectN));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic completeRun;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    totalChecks++;
    if (s !== x) begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'h0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic upd;
    @(posedge mclk);
    controlUpdate <= 1'h1;
    @(posedge mclk);
    controlUpdate <= 1'h0;
    @(negedge mclk);
  endtask
  task automatic pins(input logic f, input logic r);
    @(posedge mclk);
    fwdReq <= f; revReq <= r;
    repeat (5) @(posedge mclk);
  endtask
  task automatic t_regs;
    chk({23'h0, fwdTorqueLimit}, 32'h0);
    chk({28'h0, activeMode}, 32'h0);
    rd(8'h00, 32'h12C, 1'h0); rd(8'h04, 32'h12C, 1'h0);
    rd(8'h08, 32'h64, 1'h0); rd(8'h0C, 32'h64, 1'h0);
    rd(8'h18, 32'h12C, 1'h0); rd(8'h10, 32'h0, 1'h0);
    wr(8'h24, 32'h1);
    rd(8'h24, 32'h0, 1'h1);
    $display("test regs done");
  endtask
  task automatic t_select;
    wr(8'h00, 32'hC8); wr(8'h04, 32'hFA); wr(8'h08, 32'h32); wr(8'h0C, 32'h46);
    for (int i = 3; i >= 0; i--) begin
      pins(i[1], i[0]);
      upd;
      chk({23'h0, fwdTorqueLimit}, i[1] ? 32'hC8 : 32'h32);
      chk({23'h0, revTorqueLimit}, i[0] ? 32'hFA : 32'h46);
    end
    wr(8'h08, 32'h3C);
    chk({23'h0, fwdTorqueLimit}, 32'h32);
    upd;
    chk({23'h0, fwdTorqueLimit}, 32'h3C);
    rd(8'h20, 32'h0046003C, 1'h0);
    $display("test select done");
  endtask
  task automatic t_clamp;
    wr(8'h08, 32'h1FF);
    rd(8'h08, 32'h12C, 1'h0);
    wr(8'h00, 32'h12C); wr(8'h18, 32'h50);
    pins(1'h0, 1'h1);
    upd;
    chk({23'h0, fwdTorqueLimit}, 32'h50);
    chk({23'h0, revTorqueLimit}, 32'h50);
    wr(8'h18, 32'h12C); wr(8'h08, 32'h32);
    $display("test clamp done");
  endtask
  task automatic t_analog;
    pins(1'h0, 1'h0);
    wr(8'h10, 32'h40); wr(8'h14, 32'h100);
    anaLimitMag <= 12'h200; anaLimitNeg <= 1'h1;
    upd;
    chk({23'h0, fwdTorqueLimit}, 32'h25);
    chk({23'h0, revTorqueLimit}, 32'h25);
    wr(8'h14, 32'h0);
    upd;
    chk({23'h0, fwdTorqueLimit}, 32'h32);
    chk({23'h0, revTorqueLimit}, 32'h46);
    wr(8'h14, 32'h100); wr(8'h10, 32'h60);
    pins(1'h1, 1'h1);
    upd;
    chk({28'h0, activeMode}, 32'h4);
    chk({23'h0, fwdTorqueLimit}, 32'h12C);
    chk({23'h0, revTorqueLimit}, 32'hFA);
    wr(8'h14, 32'h0);
    $display("test analog done");
  endtask
  task automatic t_modes;
    pins(1'h0, 1'h1);
    for (int i = 0; i < 11; i++) begin
      wr(8'h10, (i + 4) << 4);
      upd;
      chk({28'h0, activeMode}, {28'h0, pri[i]});
      chk({31'h0, modeSwitched}, 32'h0);
    end
    pins(1'h1, 1'h1);
    for (int i = 0; i < 3; i++) begin
      wr(8'h10, (i + 4) << 4);
      upd;
      chk({28'h0, activeMode}, i + 2);
      chk({31'h0, modeSwitched}, 32'h1);
    end
    rd(8'h1C, 32'h84, 1'h0);
    wr(8'h10, 32'h70);
    upd;
    chk({28'h0, activeMode}, 32'h3);
    chk({31'h0, modeSwitched}, 32'h0);
    $display("test modes done");
  endtask
  // ----------------------------------------
  // Sequence and timeout
  // ----------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      completeRun;
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'h0;
    t_regs;
    t_select;
    t_clamp;
    t_analog;
    t_modes;
    completeRun;
  end
endmodule
bind tlms_torque_limit_mode_select tlms_monitor i_tlms_monitor (.mclk(mclk), .reset(reset),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fwdLimitSelectN(fwdLimitSelectN), .revLimitSelectN(revLimitSelectN),
  .controlUpdate(controlUpdate), .fwdTorqueLimit(fwdTorqueLimit),
  .revTorqueLimit(revTorqueLimit), .activeMode(activeMode), .modeSwitched(modeSwitched));
`default_nettype wire
